// ==== core/drt_pkg.sv ====
// Package with register indices, field positions and reset values of the dual reload timer control.
package drt_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [15:0] IDX_PAIR_CTRL    = 16'hFF80;
    localparam logic [15:0] IDX_B_CTRL       = 16'hFF81;
    localparam logic [15:0] IDX_A_RELOAD     = 16'hFF82;
    localparam logic [15:0] IDX_B_RELOAD     = 16'hFF83;

    ////////////////////////////////////////////////////////////////////////////
    localparam int          BIT_MODE16       = 7;
    localparam int          BIT_FILTER_EN    = 6;
    localparam int          BIT_RES_HI       = 4;
    localparam int          BIT_RES_LO       = 3;
    localparam int          BIT_RUN          = 2;
    localparam int          BIT_PRESET       = 1;
    localparam int          BIT_EXT_CLK      = 0;
    localparam int          CTRL_W           = 5;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic        MODE16_RST       = 1'b0;
    localparam logic        FILTER_EN_RST    = 1'b0;
    localparam logic        RUN_RST          = 1'b0;
    localparam logic        EXT_CLK_RST      = 1'b0;
    localparam logic [1:0]  RES_RST          = 2'h0;
    localparam logic [7:0]  RELOAD_RST       = 8'hFF;
    localparam logic [31:0] RDATA_RST        = 32'h0000_0000;

endpackage

// ==== core/drt_tmr_if.sv ====
// Interface joining the register decoder to one timer's control and reload storage.
`timescale 1ns/1ns
interface drt_tmr_if;
    logic       wr_ctrl;
    logic       wr_reload;
    logic [7:0] wdata;
    logic [4:0] ctrl_q;
    logic [7:0] reload_q;
    logic       run;
    logic       ext_clk;
    logic       preset;

    modport bus (
        output wr_ctrl,
        output wr_reload,
        output wdata,
        input  ctrl_q,
        input  reload_q,
        input  run,
        input  ext_clk,
        input  preset
    );

    modport tmr (
        input  wr_ctrl,
        input  wr_reload,
        input  wdata,
        output ctrl_q,
        output reload_q,
        output run,
        output ext_clk,
        output preset
    );
endinterface

// ==== core/drt_tmr_regs.sv ====
// Control bits and reload value of one timer, with its one-cycle preset strobe.
`timescale 1ns/1ns
module drt_tmr_regs (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    drt_tmr_if.tmr    tif
);

    logic       run_ff;
    logic       ext_clk_ff;
    logic       preset_ff;
    logic [1:0] res_ff;
    logic [7:0] reload_ff;
    logic       nxt_run;
    logic       nxt_ext_clk;
    logic       nxt_preset;
    logic [1:0] nxt_res;
    logic [7:0] nxt_reload;

    ////////////////////////////////////////////////////////////////////////////
    assign nxt_run     = tif.wr_ctrl ? tif.wdata[drt_pkg::BIT_RUN] : run_ff;
    assign nxt_ext_clk = tif.wr_ctrl ? tif.wdata[drt_pkg::BIT_EXT_CLK] : ext_clk_ff;
    assign nxt_res     = tif.wr_ctrl ? tif.wdata[drt_pkg::BIT_RES_HI:drt_pkg::BIT_RES_LO]
                                     : res_ff;
    // A zero written to the preset bit is simply no strobe.
    assign nxt_preset  = tif.wr_ctrl & tif.wdata[drt_pkg::BIT_PRESET];
    assign nxt_reload  = tif.wr_reload ? tif.wdata : reload_ff;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            run_ff     <= drt_pkg::RUN_RST;
            ext_clk_ff <= drt_pkg::EXT_CLK_RST;
            preset_ff  <= 1'b0;
            res_ff     <= drt_pkg::RES_RST;
            reload_ff  <= drt_pkg::RELOAD_RST;
        end else begin
            run_ff     <= nxt_run;
            ext_clk_ff <= nxt_ext_clk;
            preset_ff  <= nxt_preset;
            res_ff     <= nxt_res;
            reload_ff  <= nxt_reload;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The preset bit is write-only, so its read position is a constant zero.
    assign tif.ctrl_q   = {res_ff, run_ff, 1'b0, ext_clk_ff};
    assign tif.reload_q = reload_ff;
    assign tif.run      = run_ff;
    assign tif.ext_clk  = ext_clk_ff;
    assign tif.preset   = preset_ff;

endmodule

// ==== core/drt_ctrl_top.sv ====
// APB register block for the control and reload data of a pair of 8-bit timers.
//
// Contract
// - Mode bit set joins both timers as one 16-bit counter; reset 0.
// - Filter enable bit switches noise rejection on external clock two; reset off.
// - Timer A clock select: 1 external, 0 internal; reset internal.
// - Timer B clock select: 1 external, 0 internal; reset internal.
// - Timer A holds an 8-bit read/write reload value, resetting to all ones.
// - Timer B holds an 8-bit read/write reload value, resetting to all ones.
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
module drt_ctrl_top #(
    parameter int ADDR_W = 18
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   pair_mode16,
    output logic                   ext_clk2_filter_en,
    output logic                   timer_a_run,
    output logic                   timer_a_ext_clk,
    output logic                   timer_a_preset,
    output logic      [7:0]        timer_a_reload,
    output logic                   timer_b_run,
    output logic                   timer_b_ext_clk,
    output logic                   timer_b_preset,
    output logic      [7:0]        timer_b_reload
);

    localparam int NUM_TMR = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices are word positions: the byte address is four times the index.
    function automatic logic drt_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [15:0]       idx);
        logic [ADDR_W-1:0] byte_addr;
        byte_addr = ADDR_W'({idx, 2'b00});
        drt_hit   = (addr == byte_addr);
    endfunction

    logic        pready_ff;
    logic        pslverr_ff;
    logic [31:0] prdata_ff;
    logic        mode16_ff;
    logic        filter_en_ff;
    logic        nxt_pready;
    logic        nxt_pslverr;
    logic [31:0] nxt_prdata;
    logic        nxt_mode16;
    logic        nxt_filter_en;

    drt_tmr_if tif[NUM_TMR] ();

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.
    wire         hit_pair_ctrl = drt_hit(paddr, drt_pkg::IDX_PAIR_CTRL);
    wire         hit_b_ctrl    = drt_hit(paddr, drt_pkg::IDX_B_CTRL);
    wire         hit_a_reload  = drt_hit(paddr, drt_pkg::IDX_A_RELOAD);
    wire         hit_b_reload  = drt_hit(paddr, drt_pkg::IDX_B_RELOAD);
    wire         hit_any       = hit_pair_ctrl | hit_b_ctrl | hit_a_reload | hit_b_reload;

    wire         setup_phase   = psel & ~penable;
    // The slave answers in the first access cycle, so no wait state is ever inserted.
    wire         access_done   = psel & penable & pready_ff;
    // Data sits in byte lane 0; a write that leaves that lane unstrobed changes nothing.
    wire         wr_commit     = access_done & pwrite & pstrb[0] & hit_any;
    wire [7:0]   wbyte         = pwdata[7:0];

    wire         wr_pair_ctrl  = wr_commit & hit_pair_ctrl;
    wire         wr_b_ctrl     = wr_commit & hit_b_ctrl;
    wire         wr_a_reload   = wr_commit & hit_a_reload;
    wire         wr_b_reload   = wr_commit & hit_b_reload;

    ////////////////////////////////////////////////////////////////////////////
    // Read selection; bit 5 of the pair control register always reads zero.
    wire [7:0]   rd_pair_ctrl  = {mode16_ff, filter_en_ff, 1'b0, tif[0].ctrl_q};
    wire [7:0]   rd_b_ctrl     = {3'b000, tif[1].ctrl_q};

    wire [7:0]   rd_byte       = hit_pair_ctrl ? rd_pair_ctrl      :
                                 hit_b_ctrl    ? rd_b_ctrl         :
                                 hit_a_reload  ? tif[0].reload_q   :
                                 hit_b_reload  ? tif[1].reload_q   :
                                                 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Bus answer state.
    assign nxt_pready    = setup_phase;
    assign nxt_pslverr   = setup_phase & ~hit_any;
    // Read data is caught in the setup cycle and held through the access phase.
    assign nxt_prdata    = (setup_phase & ~pwrite) ? {24'h00_0000, rd_byte} :
                           setup_phase             ? drt_pkg::RDATA_RST       :
                                                     prdata_ff;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= drt_pkg::RDATA_RST;
        end else begin
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff  <= nxt_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pair-wide control bits.
    assign nxt_mode16    = wr_pair_ctrl ? wbyte[drt_pkg::BIT_MODE16] : mode16_ff;
    assign nxt_filter_en = wr_pair_ctrl ? wbyte[drt_pkg::BIT_FILTER_EN] : filter_en_ff;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mode16_ff    <= drt_pkg::MODE16_RST;
            filter_en_ff <= drt_pkg::FILTER_EN_RST;
        end else begin
            mode16_ff    <= nxt_mode16;
            filter_en_ff <= nxt_filter_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-timer storage. Timer A's control shares its register with the pair bits.
    wire [NUM_TMR-1:0] wr_ctrl_vec   = {wr_b_ctrl, wr_pair_ctrl};
    wire [NUM_TMR-1:0] wr_reload_vec = {wr_b_reload, wr_a_reload};

    genvar g;
    generate
        for (g = 0; g < NUM_TMR; g++) begin : g_tmr
            assign tif[g].wr_ctrl   = wr_ctrl_vec[g];
            assign tif[g].wr_reload = wr_reload_vec[g];
            assign tif[g].wdata     = wbyte;

            drt_tmr_regs u_tmr (
                .sys_clk (sys_clk),
                .sys_rst (sys_rst),
                .tif     (tif[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // All outputs below are register outputs passed straight through.
    assign prdata             = prdata_ff;
    assign pready             = pready_ff;
    assign pslverr            = pslverr_ff;
    assign pair_mode16        = mode16_ff;
    assign ext_clk2_filter_en = filter_en_ff;
    assign timer_a_run        = tif[0].run;
    assign timer_a_ext_clk    = tif[0].ext_clk;
    assign timer_a_preset     = tif[0].preset;
    assign timer_a_reload     = tif[0].reload_q;
    assign timer_b_run        = tif[1].run;
    assign timer_b_ext_clk    = tif[1].ext_clk;
    assign timer_b_preset     = tif[1].preset;
    assign timer_b_reload     = tif[1].reload_q;

endmodule

// ==== dv/drt_ctrl_top_assertions.sv ====
// Concurrent checks on the ports of the timer control register block.
`timescale 1ns/1ns
module drt_ctrl_top_assertions #(
    parameter int ADDR_W = 18
) (
    input wire logic              sys_clk,
    input wire logic              sys_rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              pair_mode16,
    input wire logic              ext_clk2_filter_en,
    input wire logic              timer_a_run,
    input wire logic              timer_a_ext_clk,
    input wire logic              timer_a_preset,
    input wire logic [7:0]        timer_a_reload,
    input wire logic              timer_b_run,
    input wire logic              timer_b_ext_clk,
    input wire logic              timer_b_preset,
    input wire logic [7:0]        timer_b_reload
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire acc = psel && penable && pready;
    wire wr  = acc && pwrite && pstrb[0];
    wire w0  = wr && paddr == 18'h3FE00;
    wire w1  = wr && paddr == 18'h3FE04;
    wire map = paddr == 18'h3FE00 || paddr == 18'h3FE04 || paddr == 18'h3FE08
               || paddr == 18'h3FE0C;
    ////////////////////////////////////////////////////////////////////////
    a_pready_pulse: assert property (pready |=> !pready) else $error("pready held");
    a_unmapped_err: assert property (acc |-> pslverr == !map) else $error("slave error wrong");
    a_mode_write: assert property (w0 |=> pair_mode16 == $past(pwdata[7])
        && ext_clk2_filter_en == $past(pwdata[6])) else $error("mode or filter bit wrong");
    a_a_ctrl_write: assert property (w0 |=> timer_a_run == $past(pwdata[2])
        && timer_a_ext_clk == $past(pwdata[0])) else $error("timer a control wrong");
    a_b_ctrl_write: assert property (w1 |=> timer_b_run == $past(pwdata[2])
        && timer_b_ext_clk == $past(pwdata[0])) else $error("timer b control wrong");
    a_reload_a: assert property (wr && paddr == 18'h3FE08
        |=> timer_a_reload == $past(pwdata[7:0])) else $error("timer a reload wrong");
    a_reload_b_hold: assert property (!(wr && paddr == 18'h3FE0C)
        |=> $stable(timer_b_reload)) else $error("timer b reload changed");
    a_preset_cause: assert property (timer_a_preset |-> $past(w0) && $past(pwdata[1]))
        else $error("stray preset a");
    a_preset_b_pulse: assert property (timer_b_preset |=> !timer_b_preset)
        else $error("preset b held");
    a_reset_state: assert property ($fell(sys_rst)
        |-> timer_a_reload == 8'hFF && timer_b_reload == 8'hFF && !pair_mode16
        && !ext_clk2_filter_en && !timer_a_ext_clk && !timer_b_ext_clk && !timer_a_run
        && !timer_b_run && !timer_a_preset && !timer_b_preset && !pready && !pslverr)
        else $error("reset state wrong");
endmodule
bind drt_ctrl_top drt_ctrl_top_assertions #(.ADDR_W(ADDR_W)) u_drt_ctrl_top_assertions (
    .sys_clk            (sys_clk),
    .sys_rst            (sys_rst),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .pstrb              (pstrb),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .pair_mode16        (pair_mode16),
    .ext_clk2_filter_en (ext_clk2_filter_en),
    .timer_a_run        (timer_a_run),
    .timer_a_ext_clk    (timer_a_ext_clk),
    .timer_a_preset     (timer_a_preset),
    .timer_a_reload     (timer_a_reload),
    .timer_b_run        (timer_b_run),
    .timer_b_ext_clk    (timer_b_ext_clk),
    .timer_b_preset     (timer_b_preset),
    .timer_b_reload     (timer_b_reload)
);

// ==== dv/tb_drt_ctrl_top.sv ====
// Self-checking bench for the timer control register block.
`timescale 1ns/1ns
module tb_drt_ctrl_top;
    localparam logic [17:0] A0 = {drt_pkg::IDX_PAIR_CTRL, 2'h0};
    localparam logic [17:0] A1 = {drt_pkg::IDX_B_CTRL, 2'h0};
    localparam logic [17:0] A2 = {drt_pkg::IDX_A_RELOAD, 2'h0};
    localparam logic [17:0] A3 = {drt_pkg::IDX_B_RELOAD, 2'h0};
    logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err, pa, pb;
    logic        pair_mode16, ext_clk2_filter_en, timer_a_run, timer_a_ext_clk;
    logic        timer_a_preset, timer_b_run, timer_b_ext_clk, timer_b_preset;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [7:0]  timer_a_reload, timer_b_reload, m0, m1, m2, m3;
    logic [17:0] ad [7] = '{A0, A1, A2, A3, 18'h3FE10, 18'h3FE01, 18'h00000};
    int          num_errors, num_checks, seed, cyc;
    drt_ctrl_top #(.ADDR_W(18)) u_drt_ctrl_top (
        .sys_clk            (sys_clk),
        .sys_rst            (sys_rst),
        .psel               (psel),
        .penable            (penable),
        .pwrite             (pwrite),
        .paddr              (paddr),
        .pwdata             (pwdata),
        .pstrb              (pstrb),
        .prdata             (prdata),
        .pready             (pready),
        .pslverr            (pslverr),
        .pair_mode16        (pair_mode16),
        .ext_clk2_filter_en (ext_clk2_filter_en),
        .timer_a_run        (timer_a_run),
        .timer_a_ext_clk    (timer_a_ext_clk),
        .timer_a_preset     (timer_a_preset),
        .timer_a_reload     (timer_a_reload),
        .timer_b_run        (timer_b_run),
        .timer_b_ext_clk    (timer_b_ext_clk),
        .timer_b_preset     (timer_b_preset),
        .timer_b_reload     (timer_b_reload)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    function automatic logic [31:0] exp_rd(input logic [17:0] a);
        case (a)
            A0: return {24'h0, m0[7:6], 1'h0, m0[4:2], 1'h0, m0[0]};
            A1: return {27'h0, m1[4:2], 1'h0, m1[0]};
            A2: return {24'h0, m2};
            A3: return {24'h0, m3};
            default: return 32'h0;
        endcase
    endfunction
    // Request held until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge sys_clk);
        penable <= 1'h1;
        do @(posedge sys_clk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        #1;
        pa = timer_a_preset;
        pb = timer_b_preset;
    endtask
    task automatic op(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s);
        logic map;
        map = a == A0 || a == A1 || a == A2 || a == A3;
        apb(1'h1, a, d, s);
        chk("wr_err", {31'h0, err}, {31'h0, !map});
        chk("preset", {30'h0, pa, pb},
            {30'h0, s[0] && d[1] && a == A0, s[0] && d[1] && a == A1});
        if (s[0] && a == A0) m0 = d[7:0];
        if (s[0] && a == A1) m1 = d[7:0];
        if (s[0] && a == A2) m2 = d[7:0];
        if (s[0] && a == A3) m3 = d[7:0];
        apb(1'h0, a, 32'h0, 4'h0);
        chk("rdata", rd, exp_rd(a));
        chk("outs", {10'h0, pair_mode16, ext_clk2_filter_en, timer_a_run, timer_a_ext_clk,
            timer_b_run, timer_b_ext_clk, timer_a_reload, timer_b_reload},
            {10'h0, m0[7], m0[6], m0[2], m0[0], m1[2], m1[0], m2, m3});
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'h0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            results();
        end
    end
    initial begin
        {sys_rst, psel, penable, pwrite, paddr, pwdata, pstrb} = {4'h8, 54'h0};
        {m0, m1, m2, m3} = 32'h0000_FFFF;
        seed = 8362;
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'h0;
        foreach (ad[i]) begin
            apb(1'h0, ad[i], 32'h0, 4'h0);
            chk("reset", rd, exp_rd(ad[i]));
        end
        op(A0, 32'hFF, 4'h1);
        op(A1, 32'hFF, 4'h1);
        op(A0, 32'h00, 4'hE);
        op(A2, 32'h00, 4'hF);
        op(A3, 32'h80, 4'hF);
        repeat (60) op(ad[3'($unsigned($random(seed)) % 7)], 32'($random(seed)),
                       4'($random(seed)));
        // A second reset after random writes must bring every register back.
        @(posedge sys_clk);
        sys_rst <= 1'h1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'h0;
        {m0, m1, m2, m3} = 32'h0000_FFFF;
        foreach (ad[i]) begin
            apb(1'h0, ad[i], 32'h0, 4'h0);
            chk("rst_again", rd, exp_rd(ad[i]));
        end
        results();
    end
endmodule
